// File: src/sadc_defines.svh
// sadc_defines.svh: constants for the serial converter link
// assumes: included by the package and both ends by bare name
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH
`define SADC_NUM_CH      4'h8
`define SADC_RES_W       5'h10
`define SADC_CMD_W       4'h8
`define SADC_CMD_START   3'h7
`define SADC_CMD_SGL     3'h2
`define SADC_CONV_CYC    8'h10
`define SADC_HALF_CYC    8'h04
`define SADC_SAMPLE_NS   32'd50000
`define SADC_CLK_NS      32'd4
`define SADC_GAP_CYC     (`SADC_SAMPLE_NS / `SADC_CLK_NS)
`endif

// File: src/sadc_pkg.sv
// sadc_pkg.sv: shared types for the serial converter link
// assumes: sadc_defines.svh on the include path
`include "sadc_defines.svh"
package sadc_pkg;
  typedef logic [15:0] sadc_word_t;
  typedef logic [2:0]  sadc_chan_t;
  typedef logic [7:0]  sadc_cmd_t;
endpackage : sadc_pkg

// File: src/sadc_link_if.sv
// sadc_link_if.sv: serial pins between host and converter
// assumes: one clock, both ends in the same domain
interface sadc_link_if;
  logic sel_n;
  logic strobe;
  logic cmd_in;
  logic dout_o;
  logic dout_oe;
  logic busy_n_o;
  logic busy_n_oe;
  wire  dout_line   = dout_oe   ? dout_o   : 1'b1;
  wire  busy_n_line = busy_n_oe ? busy_n_o : 1'b1;
  modport device (input sel_n, input strobe, input cmd_in,
                  output dout_o, output dout_oe,
                  output busy_n_o, output busy_n_oe);
  modport host (output sel_n, output strobe, output cmd_in,
                input dout_line);
endinterface : sadc_link_if

// File: src/sadc_device.sv
// sadc_device.sv: converter end of the serial link
// assumes: strobe and select synchronous to sys_clk_i, analog values
// presented as parallel words per channel
`include "sadc_defines.svh"
module sadc_device (
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                resetn_i,
  // analog sample values
  input  wire sadc_pkg::sadc_word_t ain_i [8],
  // link
  sadc_link_if.device              link,
  // status
  output logic                     diff_mode_o,
  output sadc_pkg::sadc_chan_t     last_chan_o
);
  import sadc_pkg::*;

  typedef enum logic [1:0] {SADC_IDLE, SADC_CMD, SADC_CONV, SADC_OUT}
    sadc_dev_st_t;

  // ----------------------------------------
  // state
  // ----------------------------------------
  sadc_dev_st_t st_reg;
  sadc_cmd_t    cmd_reg;
  logic [4:0]   cnt_reg;
  logic [7:0]   conv_reg;
  sadc_word_t   res_reg;
  logic         strobe_d_reg;
  logic         dout_reg;
  logic         dout_oe_reg;
  logic         busy_oe_reg;
  logic         busy_n_reg;
  logic         diff_reg;
  sadc_chan_t   chan_reg;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire        sel       = ~link.sel_n;
  wire        rise      = link.strobe & ~strobe_d_reg;
  wire        fall      = ~link.strobe & strobe_d_reg;
  wire        cmd_start = (st_reg == SADC_IDLE) & rise & link.cmd_in;
  wire        cmd_done  = (st_reg == SADC_CMD) & rise &
                          (cnt_reg == 5'(`SADC_CMD_W - 4'h2));
  wire [7:0]  cmd_full  = {cmd_reg[6:0], link.cmd_in};
  wire        sgl       = cmd_full[`SADC_CMD_SGL];
  wire [2:0]  chan_sel  = cmd_full[6:4];
  wire [16:0] diff_val  = {1'b0, ain_i[{chan_sel[2:1], 1'b0}]} -
                          {1'b0, ain_i[{chan_sel[2:1], 1'b1}]};
  wire [15:0] diff_res  = diff_val[16] ? 16'h0000 : diff_val[15:0];
  wire [15:0] sample    = sgl ? ain_i[chan_sel] : diff_res;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg       <= SADC_IDLE;
      cmd_reg      <= 8'h00;
      cnt_reg      <= 5'h00;
      conv_reg     <= 8'h00;
      res_reg      <= 16'h0000;
      strobe_d_reg <= 1'b0;
      diff_reg     <= 1'b0;
      chan_reg     <= 3'h0;
    end else begin
      strobe_d_reg <= link.strobe;
      if (!sel) begin
        st_reg <= SADC_IDLE;
        cnt_reg <= 5'h00;
      end else begin
        unique case (st_reg)
          SADC_IDLE: begin
            if (cmd_start) begin
              st_reg  <= SADC_CMD;
              cmd_reg <= 8'h01;
              cnt_reg <= 5'h00;
            end
          end
          SADC_CMD: begin
            if (rise) begin
              cmd_reg <= cmd_full;
              cnt_reg <= cnt_reg + 5'h01;
              if (cmd_done) begin
                st_reg   <= SADC_CONV;
                conv_reg <= 8'h00;
                diff_reg <= ~sgl;
                chan_reg <= chan_sel;
                res_reg  <= sample;
              end
            end
          end
          SADC_CONV: begin
            if (fall) begin
              conv_reg <= conv_reg + 8'h01;
              // fall 8 ends the command, fall 9 the conversion pulse
              if (conv_reg == 8'h01) begin
                st_reg  <= SADC_OUT;
                cnt_reg <= 5'h00;
              end
            end
          end
          SADC_OUT: begin
            if (fall) begin
              res_reg <= {res_reg[14:0], 1'b0};
              cnt_reg <= cnt_reg + 5'h01;
              if (cnt_reg == 5'(`SADC_RES_W - 5'h01))
                st_reg <= SADC_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  wire out_next  = (st_reg == SADC_OUT) ? res_reg[15] : 1'b0;
  wire busy_next = ~((st_reg == SADC_CMD) | (st_reg == SADC_CONV) |
                     cmd_start);

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dout_reg    <= 1'b0;
      dout_oe_reg <= 1'b0;
      busy_n_reg  <= 1'b1;
      busy_oe_reg <= 1'b0;
    end else begin
      dout_reg    <= out_next;
      dout_oe_reg <= sel;
      busy_n_reg  <= busy_next;
      busy_oe_reg <= sel;
    end
  end

  assign link.dout_o    = dout_reg;
  assign link.dout_oe   = dout_oe_reg;
  assign link.busy_n_o  = busy_n_reg;
  assign link.busy_n_oe = busy_oe_reg;
  assign diff_mode_o    = diff_reg;
  assign last_chan_o    = chan_reg;
endmodule : sadc_device

// File: src/sadc_host.sv
// sadc_host.sv: host end, bit-bangs select, strobe and command
// assumes: converter result pin read as a plain input
`include "sadc_defines.svh"
module sadc_host #(
  parameter int GAP_CYC = `SADC_GAP_CYC
) (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 resetn_i,
  // request
  input  wire logic                 start_i,
  input  wire sadc_pkg::sadc_chan_t chan_i,
  input  wire logic                 diff_i,
  output logic                      ready_o,
  // answer
  output logic                      done_o,
  output sadc_pkg::sadc_word_t      result_o,
  // link
  sadc_link_if.host                 link
);
  import sadc_pkg::*;

  typedef enum logic [2:0] {SADC_H_IDLE, SADC_H_LOW, SADC_H_HIGH,
                            SADC_H_END, SADC_H_GAP} sadc_host_st_t;

  // ----------------------------------------
  // state
  // ----------------------------------------
  sadc_host_st_t st_reg;
  logic [4:0]    bit_reg;
  logic [7:0]    half_reg;
  logic [31:0]   gap_reg;
  logic [31:0]   sh_reg;
  logic          sel_n_reg;
  logic          strobe_reg;
  logic          cmd_reg;
  logic          done_reg;
  sadc_word_t    res_reg;

  // 8 command + 1 conversion + 16 result = 25 pulses
  localparam logic [4:0] NPULSE = 5'h19;
  wire [7:0] cmd_byte = {1'b1, chan_i, 1'b0, ~diff_i, 2'b11};
  wire half_done = (half_reg == `SADC_HALF_CYC - 8'h01);
  wire last      = (bit_reg == NPULSE - 5'h01);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_reg <= SADC_H_IDLE;
      bit_reg <= 5'h00;
      half_reg <= 8'h00;
      gap_reg <= 32'h0;
      sh_reg <= 32'h0;
      sel_n_reg <= 1'b1;
      strobe_reg <= 1'b0;
      cmd_reg <= 1'b0;
      done_reg <= 1'b0;
      res_reg <= 16'h0000;
    end else begin
      done_reg <= 1'b0;
      half_reg <= half_done ? 8'h00 : half_reg + 8'h01;
      if (gap_reg != 32'h0) gap_reg <= gap_reg - 32'h1;
      unique case (st_reg)
        SADC_H_IDLE: begin
          half_reg <= 8'h00;
          if (start_i && gap_reg == 32'h0) begin
            sel_n_reg <= 1'b0;
            sh_reg    <= {cmd_byte, 24'h0};
            cmd_reg   <= cmd_byte[7];
            bit_reg   <= 5'h00;
            gap_reg   <= 32'(GAP_CYC);
            st_reg    <= SADC_H_LOW;
          end
        end
        SADC_H_LOW: if (half_done) begin
          strobe_reg <= 1'b1;
          st_reg     <= SADC_H_HIGH;
        end
        SADC_H_HIGH: if (half_done) begin
          strobe_reg <= 1'b0;
          sh_reg     <= {sh_reg[30:0], 1'b0};
          cmd_reg    <= sh_reg[30];
          bit_reg    <= bit_reg + 5'h01;
          st_reg     <= last ? SADC_H_END : SADC_H_LOW;
        end
        SADC_H_END: if (half_done) begin
          // frame ends; busy is never consulted
          sel_n_reg <= 1'b1;
          done_reg  <= 1'b1;
          st_reg    <= SADC_H_GAP;
        end
        SADC_H_GAP: st_reg <= SADC_H_IDLE;
      endcase
      // sample each result bit just before the strobe rises
      if (st_reg == SADC_H_LOW && half_done && bit_reg > 5'(`SADC_CMD_W))
        res_reg <= {res_reg[14:0], link.dout_line};
    end
  end

  assign link.sel_n  = sel_n_reg;
  assign link.strobe = strobe_reg;
  assign link.cmd_in = cmd_reg;
  assign ready_o     = (st_reg == SADC_H_IDLE) && (gap_reg == 32'h0);
  assign done_o      = done_reg;
  assign result_o    = res_reg;
endmodule : sadc_host

// File: dv/sadc_link_chk.sv
// sadc_link_chk.sv: assertions on the serial converter link
// assumes: instantiated beside the link interface, one clock
module sadc_link_chk #(
  parameter int GAP_CYC = 300
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // link pins
  input wire logic sel_n,
  input wire logic strobe,
  input wire logic cmd_in,
  input wire logic dout_o,
  input wire logic dout_oe,
  input wire logic busy_n_o,
  input wire logic busy_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // frame counters
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic [5:0]  pulse_cnt_reg;
  logic [15:0] gap_cnt_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pulse_cnt_reg <= 6'h00;
      gap_cnt_reg   <= 16'hffff;
    end else begin
      pulse_cnt_reg <= $fell(sel_n) ? 6'h00 : pulse_cnt_reg + 6'($rose(strobe));
      gap_cnt_reg   <= $fell(sel_n) ? 16'h0001
                       : gap_cnt_reg + 16'(gap_cnt_reg != 16'hffff);
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  sequence s_high;
    strobe [*4];
  endsequence
  sequence s_busy;
    busy_n_oe && !busy_n_o;
  endsequence
  property p_drive; $fell(sel_n) |=> dout_oe; endproperty
  property p_release; $rose(sel_n) |=> !dout_oe && !busy_n_oe; endproperty
  property p_busy_hiz; sel_n && $past(sel_n) |-> !busy_n_oe; endproperty
  property p_busy_low; $fell(sel_n) |-> ##[1:40] s_busy; endproperty
  property p_cmd_stable; $rose(strobe) |-> $stable(cmd_in); endproperty
  property p_pulse; $rose(strobe) |-> s_high ##1 !strobe; endproperty
  property p_frame; $rose(sel_n) |-> pulse_cnt_reg == 6'd25; endproperty
  property p_gap; $fell(sel_n) |-> gap_cnt_reg >= 16'(GAP_CYC); endproperty
  property p_dout_hold;
    strobe && $past(strobe) |-> $stable(dout_o);
  endproperty
  a_drive: assert property (p_drive)
    else $error("result pin not driven after select");
  a_release: assert property (p_release)
    else $error("pins still driven after deselect");
  a_busy_hiz: assert property (p_busy_hiz)
    else $error("busy driven while deselected");
  a_busy_low: assert property (p_busy_low)
    else $error("busy not low in frame");
  a_cmd_stable: assert property (p_cmd_stable)
    else $error("command bit moved at strobe rise");
  a_pulse: assert property (p_pulse)
    else $error("strobe high time wrong");
  a_frame: assert property (p_frame)
    else $error("strobe count per frame wrong");
  a_gap: assert property (p_gap)
    else $error("frames too close");
  a_dout_hold: assert property (p_dout_hold)
    else $error("result bit moved while strobe high");
endmodule : sadc_link_chk

// File: dv/serial_adc_interface_test.sv
// serial_adc_interface_test.sv: host and converter joined, self-checking
// assumes: src package, header, interface and both ends compiled first
module serial_adc_interface_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sadc_pkg::*;
  localparam int GAP = 300;
  logic       sys_clk_i = 1'b0;
  logic       resetn_i  = 1'b0;
  logic       start_i   = 1'b0;
  sadc_chan_t chan_i    = 3'h0;
  logic       diff_i    = 1'b0;
  sadc_word_t ain [8];
  logic       ready_o, done_o, diff_mode_o;
  sadc_word_t result_o;
  sadc_chan_t last_chan_o;
  int         n_fail    = 0;
  int         compares  = 0;
  sadc_link_if link();
  sadc_device u_sadc_device (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .ain_i(ain), .link(link), .diff_mode_o(diff_mode_o),
    .last_chan_o(last_chan_o));
  sadc_host #(.GAP_CYC(GAP)) u_sadc_host (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .start_i(start_i), .chan_i(chan_i),
    .diff_i(diff_i), .ready_o(ready_o), .done_o(done_o),
    .result_o(result_o), .link(link));
  sadc_link_chk #(.GAP_CYC(GAP)) u_sadc_link_chk (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .sel_n(link.sel_n), .strobe(link.strobe),
    .cmd_in(link.cmd_in), .dout_o(link.dout_o), .dout_oe(link.dout_oe),
    .busy_n_o(link.busy_n_o), .busy_n_oe(link.busy_n_oe));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic conv(sadc_chan_t ch, logic df, sadc_word_t exp);
    int   n;
    int   pulses;
    logic prev;
    n = 0;
    pulses = 0;
    prev = 1'b0;
    while (ready_o !== 1'b1 && n < 1000) begin
      @(negedge sys_clk_i);
      n++;
    end
    check("ready", ready_o, 1'b1);
    @(posedge sys_clk_i);
    start_i <= 1'b1;
    chan_i  <= ch;
    diff_i  <= df;
    @(posedge sys_clk_i);
    start_i <= 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 1000) begin
      @(negedge sys_clk_i);
      pulses += int'(link.strobe === 1'b1 && !prev);
      prev = link.strobe;
      n++;
    end
    check("done", done_o, 1'b1);
    check("pulses", 16'(pulses), 16'd25);
    check("result", result_o, exp);
    check("channel", last_chan_o, ch);
    check("mode", diff_mode_o, df);
  endtask : conv
  task automatic t_idle;
    @(negedge sys_clk_i);
    check("dout_line", link.dout_line, 1'b1);
    check("busy_line", link.busy_n_line, 1'b1);
  endtask : t_idle
  task automatic t_single;
    for (int i = 0; i < 8; i++) conv(3'(i), 1'b0, ain[i]);
  endtask : t_single
  task automatic t_diff;
    @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) ain[i] <= (i % 2 == 0) ? 16'h5321 : 16'h1321;
    for (int i = 0; i < 8; i++) conv(3'(i), 1'b1, 16'h4000);
    @(posedge sys_clk_i);
    ain[0] <= 16'h0100;
    conv(3'h0, 1'b1, 16'h0000);
  endtask : t_diff
  task automatic t_refuse;
    conv(3'h7, 1'b0, 16'h1321);
    @(negedge sys_clk_i);
    check("ready", ready_o, 1'b0);
    @(posedge sys_clk_i);
    start_i <= 1'b1;
    repeat (20) @(negedge sys_clk_i);
    check("sel_n", link.sel_n, 1'b1);
    @(posedge sys_clk_i);
    start_i <= 1'b0;
  endtask : t_refuse
  // ------------------------------------------------------------
  // run
  // ------------------------------------------------------------
  always #2 sys_clk_i = ~sys_clk_i;
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 8; i++) ain[i] = 16'h8001 + 16'(i) * 16'h1234;
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    t_idle();
    t_single();
    t_diff();
    t_refuse();
    end_of_test();
  end
endmodule : serial_adc_interface_test
